// ===== spcfg_pkg.sv
// package: register map, field positions, reset values and states
package spcfg_pkg;
  localparam logic [1:0] SPCFG_ADDR_CTRL1 = 2'h0;
  localparam logic [1:0] SPCFG_ADDR_CTRL2 = 2'h1;
  localparam logic [1:0] SPCFG_ADDR_STATUS = 2'h2;
  localparam logic [1:0] SPCFG_ADDR_DATA = 2'h3;
  localparam int SPCFG_BIT_WAKE = 3;
  localparam int SPCFG_BIT_ILT = 2;
  localparam int SPCFG_BIT_PE = 1;
  localparam int SPCFG_BIT_PT = 0;
  localparam int SPCFG_BIT_TIE = 7;
  localparam int SPCFG_BIT_TX_COMPLETE_IRQ_ENABLE = 6;
  localparam int SPCFG_BIT_RIE = 5;
  localparam int SPCFG_BIT_IDLE_IRQ_ENABLE = 4;
  localparam int SPCFG_BIT_M = 4;
  localparam int SPCFG_ST_TX_BUFFER_EMPTY_FLAG = 7;
  localparam int SPCFG_ST_TC = 6;
  localparam int SPCFG_ST_RX_DATA_FULL_FLAG = 5;
  localparam int SPCFG_ST_IDLE = 4;
  localparam int SPCFG_ST_PF = 0;
  localparam logic [7:0] SPCFG_CTRL1_RST = 8'h00;
  localparam logic [7:0] SPCFG_CTRL2_RST = 8'h00;
  localparam logic [15:0] SPCFG_BAUD_DIV = 16'h0010;
  localparam logic [3:0] SPCFG_IDLE_BITS_8 = 4'hA;
  localparam logic [3:0] SPCFG_IDLE_BITS_9 = 4'hB;
  typedef enum logic [3:0] {
    SPCFG_S_IDLE = 4'h1,
    SPCFG_S_START = 4'h2,
    SPCFG_S_DATA = 4'h4,
    SPCFG_S_STOP = 4'h8
  } spcfg_state_t;
endpackage : spcfg_pkg

// ===== spcfg_fifo.sv
// module: small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module spcfg_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_reg];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule : spcfg_fifo
`default_nettype wire

// ===== spcfg_top.sv
// module: serial port with frame configuration and interrupt enables
// What this block does
// - Control bit 3 picks idle-line wakeup at 0 and address-mark at 1.
// - Bit 2 starts idle counting after the start bit at 0, stop at 1.
// - With bit 2 at 1 the stop bit and trailing ones never count as idle.
// - Bit 1 turns parity generation and checking on, and off at 0.
// - With parity on, the top bit of the character is the parity bit.
// - Bit 0 picks even parity at 0 and odd at 1 over data plus parity.
// - The second control register is readable and writable at any time.
// - Second control bit 7 enables the transmit-buffer-empty request.
// - Bit 6 enables a request while the transmit-done flag is set.
// - Bit 5 enables a request while the receive-full flag is set.
// - Bit 4 enables the idle-line detected request.
`timescale 1ns/1ns
`default_nettype none
module spcfg_top
  import spcfg_pkg::*;
#(
  parameter int FIFO_DEPTH = 8,
  parameter logic [15:0] BAUD_DIV = SPCFG_BAUD_DIV
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic rxd,
  output logic txd,
  output logic irq_tx_empty,
  output logic irq_tx_done,
  output logic irq_rx_full,
  output logic irq_idle,
  output logic wake_addr_mark
);
  //////////////////////////////////////////////////////////////////////////
  function automatic logic par_bit(input logic [8:0] d, input logic nine,
                                   input logic odd);
    logic p;
    p = ^d[7:0] ^ (nine & d[8]);
    return p ^ odd;
  endfunction : par_bit

  logic [7:0] ctrl1_reg;
  logic [7:0] ctrl2_reg;
  logic [7:0] rdata_reg;
  logic nine;
  logic parity_on;
  logic parity_kind;
  logic idle_line_type;
  logic tx_buffer_empty_flag;
  logic tx_done_flag;
  logic rx_data_full_flag;
  logic idle_flag_reg;
  logic parity_err_reg;
  logic [8:0] rx_data_reg;
  logic wr_data;
  logic rd_status_reg;
  logic rd_data;

  assign nine = ctrl1_reg[SPCFG_BIT_M];
  assign parity_on = ctrl1_reg[SPCFG_BIT_PE];
  assign parity_kind = ctrl1_reg[SPCFG_BIT_PT];
  assign idle_line_type = ctrl1_reg[SPCFG_BIT_ILT];
  assign wake_addr_mark = ctrl1_reg[SPCFG_BIT_WAKE];
  assign wr_data = reg_wr && (reg_addr == SPCFG_ADDR_DATA);
  assign rd_data = reg_rd && (reg_addr == SPCFG_ADDR_DATA);

  //////////////////////////////////////////////////////////////////////////
  // register bus
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl1_reg <= SPCFG_CTRL1_RST;
      ctrl2_reg <= SPCFG_CTRL2_RST;
    end else if (reg_wr) begin
      if (reg_addr == SPCFG_ADDR_CTRL1) begin
        ctrl1_reg <= reg_wdata;
      end
      if (reg_addr == SPCFG_ADDR_CTRL2) begin
        ctrl2_reg <= reg_wdata;
      end
    end
  end

  logic [7:0] status_word;
  always_comb begin
    status_word = 8'h00;
    status_word[SPCFG_ST_TX_BUFFER_EMPTY_FLAG] = tx_buffer_empty_flag;
    status_word[SPCFG_ST_TC] = tx_done_flag;
    status_word[SPCFG_ST_RX_DATA_FULL_FLAG] = rx_data_full_flag;
    status_word[SPCFG_ST_IDLE] = idle_flag_reg;
    status_word[SPCFG_ST_PF] = parity_err_reg;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 8'h00;
      rd_status_reg <= 1'b0;
    end else begin
      rd_status_reg <= reg_rd && (reg_addr == SPCFG_ADDR_STATUS);
      if (reg_rd) begin
        case (reg_addr)
          SPCFG_ADDR_CTRL1: rdata_reg <= ctrl1_reg;
          SPCFG_ADDR_CTRL2: rdata_reg <= ctrl2_reg;
          SPCFG_ADDR_STATUS: rdata_reg <= status_word;
          SPCFG_ADDR_DATA: rdata_reg <= rx_data_reg[7:0];
          default: rdata_reg <= 8'h00;
        endcase
      end else begin
        rdata_reg <= 8'h00;
      end
    end
  end
  assign reg_rdata = rdata_reg;

  //////////////////////////////////////////////////////////////////////////
  // interrupt requests are static levels, cleared by the flags or by their enables
  assign irq_tx_empty = ctrl2_reg[SPCFG_BIT_TIE] & tx_buffer_empty_flag;
  assign irq_tx_done = ctrl2_reg[SPCFG_BIT_TX_COMPLETE_IRQ_ENABLE] & tx_done_flag;
  assign irq_rx_full = ctrl2_reg[SPCFG_BIT_RIE] & rx_data_full_flag;
  assign irq_idle = ctrl2_reg[SPCFG_BIT_IDLE_IRQ_ENABLE] & idle_flag_reg;

  //////////////////////////////////////////////////////////////////////////
  // transmit path: data writes queue in the fifo
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic fifo_in_ready;
  logic [8:0] fifo_out_data;

  spcfg_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .nrst(nrst),
    .in_valid(wr_data),
    .in_ready(fifo_in_ready),
    .in_data({ctrl1_reg[SPCFG_BIT_M+1], reg_wdata}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );
  // a data write while the fifo is full is dropped; software watches the flag
  assign tx_buffer_empty_flag = fifo_in_ready;

  spcfg_state_t tx_state_reg;
  logic [15:0] tx_baud_reg;
  logic [3:0] tx_bit_reg;
  logic [8:0] tx_shift_reg;
  logic txd_reg;
  logic tx_tick;
  logic [3:0] tx_nbits;
  assign tx_tick = (tx_baud_reg == BAUD_DIV - 16'h0001);
  assign tx_nbits = nine ? 4'h9 : 4'h8;
  assign fifo_out_ready = (tx_state_reg == SPCFG_S_IDLE);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tx_state_reg <= SPCFG_S_IDLE;
      tx_baud_reg <= 16'h0000;
      tx_bit_reg <= 4'h0;
      tx_shift_reg <= 9'h000;
      txd_reg <= 1'b1;
    end else begin
      tx_baud_reg <= (tx_state_reg == SPCFG_S_IDLE || tx_tick) ? 16'h0000
                     : tx_baud_reg + 16'h0001;
      case (tx_state_reg)
        SPCFG_S_IDLE: begin
          txd_reg <= 1'b1;
          if (fifo_out_valid) begin
            tx_shift_reg <= fifo_out_data;
            if (parity_on) begin
              // top bit replaced by generated parity
              if (nine) begin
                tx_shift_reg[8] <= par_bit({1'b0, fifo_out_data[7:0]}, 1'b0,
                                           parity_kind);
              end else begin
                tx_shift_reg[7] <= par_bit({2'b00, fifo_out_data[6:0]}, 1'b0,
                                           parity_kind);
              end
            end
            txd_reg <= 1'b0;
            tx_state_reg <= SPCFG_S_START;
          end
        end
        SPCFG_S_START: begin
          if (tx_tick) begin
            txd_reg <= tx_shift_reg[0];
            tx_bit_reg <= 4'h1;
            tx_state_reg <= SPCFG_S_DATA;
          end
        end
        SPCFG_S_DATA: begin
          if (tx_tick) begin
            if (tx_bit_reg == tx_nbits) begin
              txd_reg <= 1'b1;
              tx_state_reg <= SPCFG_S_STOP;
            end else begin
              txd_reg <= tx_shift_reg[tx_bit_reg];
              tx_bit_reg <= tx_bit_reg + 4'h1;
            end
          end
        end
        SPCFG_S_STOP: begin
          if (tx_tick) begin
            tx_state_reg <= SPCFG_S_IDLE;
          end
        end
        default: tx_state_reg <= SPCFG_S_IDLE;
      endcase
    end
  end
  assign txd = txd_reg;
  assign tx_done_flag = (tx_state_reg == SPCFG_S_IDLE) && !fifo_out_valid;

  //////////////////////////////////////////////////////////////////////////
  // receive path: mid-bit sampling
  spcfg_state_t rx_state_reg;
  logic [15:0] rx_baud_reg;
  logic [3:0] rx_bit_reg;
  logic [8:0] rx_shift_reg;
  logic rx_tick;
  logic rx_mid;
  assign rx_tick = (rx_baud_reg == BAUD_DIV - 16'h0001);
  assign rx_mid = (rx_baud_reg == (BAUD_DIV >> 1));

  // idle detector counts whole bit times of high line
  logic [3:0] idle_cnt_reg;
  logic [15:0] idle_baud_reg;
  logic idle_armed_reg;
  logic [3:0] idle_need;
  logic char_end;
  logic start_seen;
  assign idle_need = nine ? SPCFG_IDLE_BITS_9 : SPCFG_IDLE_BITS_8;
  assign start_seen = (rx_state_reg == SPCFG_S_START) && rx_mid && !rxd;
  assign char_end = (rx_state_reg == SPCFG_S_STOP) && rx_mid;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rx_state_reg <= SPCFG_S_IDLE;
      rx_baud_reg <= 16'h0000;
      rx_bit_reg <= 4'h0;
      rx_shift_reg <= 9'h000;
      rx_data_reg <= 9'h000;
      rx_data_full_flag <= 1'b0;
      parity_err_reg <= 1'b0;
    end else begin
      rx_baud_reg <= (rx_state_reg == SPCFG_S_IDLE || rx_tick) ? 16'h0000
                     : rx_baud_reg + 16'h0001;
      // reading data clears full; a new character in that cycle wins
      if (rd_data) begin
        rx_data_full_flag <= 1'b0;
      end
      case (rx_state_reg)
        SPCFG_S_IDLE: begin
          if (!rxd) begin
            rx_state_reg <= SPCFG_S_START;
          end
        end
        SPCFG_S_START: begin
          if (rx_mid) begin
            rx_state_reg <= rxd ? SPCFG_S_IDLE : SPCFG_S_START;
          end
          if (rx_tick) begin
            rx_bit_reg <= 4'h0;
            rx_state_reg <= SPCFG_S_DATA;
          end
        end
        SPCFG_S_DATA: begin
          if (rx_mid) begin
            rx_shift_reg[rx_bit_reg] <= rxd;
            rx_bit_reg <= rx_bit_reg + 4'h1;
          end
          if (rx_tick && rx_bit_reg == tx_nbits) begin
            rx_state_reg <= SPCFG_S_STOP;
          end
        end
        SPCFG_S_STOP: begin
          if (rx_mid) begin
            rx_data_reg <= nine ? rx_shift_reg : {1'b0, rx_shift_reg[7:0]};
            rx_data_full_flag <= 1'b1;
            // ones over data plus parity bit must match the selected kind
            parity_err_reg <= parity_on &&
                              par_bit(rx_shift_reg, nine, parity_kind);
            rx_state_reg <= SPCFG_S_IDLE;
          end
        end
        default: rx_state_reg <= SPCFG_S_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      idle_cnt_reg <= 4'h0;
      idle_baud_reg <= 16'h0000;
      idle_armed_reg <= 1'b1;
      idle_flag_reg <= 1'b0;
    end else begin
      if (rd_status_reg && idle_flag_reg) begin
        idle_flag_reg <= 1'b0;
      end
      if (start_seen) begin
        // type 0 counts from the start bit, so trailing ones add up
        idle_cnt_reg <= 4'h0;
        idle_baud_reg <= 16'h0000;
        idle_armed_reg <= !idle_line_type;
      end else if (char_end && idle_line_type) begin
        idle_cnt_reg <= 4'h0;
        idle_baud_reg <= 16'h0000;
        idle_armed_reg <= 1'b1;
      end else if (!rxd) begin
        idle_cnt_reg <= 4'h0;
        idle_baud_reg <= 16'h0000;
      end else if (idle_armed_reg && rx_state_reg == SPCFG_S_IDLE ||
                   idle_armed_reg && !idle_line_type) begin
        idle_baud_reg <= (idle_baud_reg == BAUD_DIV - 16'h0001) ? 16'h0000
                         : idle_baud_reg + 16'h0001;
        if (idle_baud_reg == BAUD_DIV - 16'h0001) begin
          if (idle_cnt_reg == idle_need - 4'h1) begin
            idle_flag_reg <= 1'b1;
            idle_armed_reg <= 1'b0;
            idle_cnt_reg <= 4'h0;
          end else begin
            idle_cnt_reg <= idle_cnt_reg + 4'h1;
          end
        end
      end
    end
  end
endmodule : spcfg_top
`default_nettype wire

// ===== spcfg_monitor.sv
// checker: port-level assertions for the serial port block
`timescale 1ns/1ns
`default_nettype none
module spcfg_monitor
  import spcfg_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic rxd,
  input wire logic txd,
  input wire logic irq_tx_empty,
  input wire logic irq_tx_done,
  input wire logic irq_rx_full,
  input wire logic irq_idle,
  input wire logic wake_addr_mark
);
  logic [7:0] ctrl2_reg;
  // shadow of the second control register, built from bus writes only
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl2_reg <= SPCFG_CTRL2_RST;
    end else if (reg_wr && reg_addr == SPCFG_ADDR_CTRL2) begin
      ctrl2_reg <= reg_wdata;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_ctrl2_rd;
    reg_rd && reg_addr == SPCFG_ADDR_CTRL2;
  endsequence
  sequence s_ctrl1_wr;
    reg_wr && reg_addr == SPCFG_ADDR_CTRL1;
  endsequence
  sequence s_data_wr;
    reg_wr && reg_addr == SPCFG_ADDR_DATA && ctrl2_reg[SPCFG_BIT_TX_COMPLETE_IRQ_ENABLE];
  endsequence
  a_tx_empty_gate: assert property (!ctrl2_reg[7] |-> !irq_tx_empty)
    else $error("tx empty request without its enable");
  a_tx_done_gate: assert property (!ctrl2_reg[6] |-> !irq_tx_done)
    else $error("tx done request without its enable");
  a_rx_full_gate: assert property (!ctrl2_reg[5] |-> !irq_rx_full)
    else $error("rx full request without its enable");
  a_idle_gate: assert property (!ctrl2_reg[4] |-> !irq_idle)
    else $error("idle request without its enable");
  a_ctrl2_readback: assert property (s_ctrl2_rd |=> reg_rdata == $past(ctrl2_reg))
    else $error("second control register read back wrong");
  a_wake_follow: assert property (s_ctrl1_wr |=> wake_addr_mark == $past(reg_wdata[3]))
    else $error("wakeup method output does not follow its bit");
  a_tx_done_drop: assert property (s_data_wr |-> ##[1:3] !irq_tx_done)
    else $error("tx done request stays up after new data");
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside the read answer cycle");
endmodule : spcfg_monitor
bind spcfg_top spcfg_monitor u_mon (.core_clk(core_clk), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd(rxd), .txd(txd),
  .irq_tx_empty(irq_tx_empty), .irq_tx_done(irq_tx_done),
  .irq_rx_full(irq_rx_full), .irq_idle(irq_idle),
  .wake_addr_mark(wake_addr_mark));
`default_nettype wire

// ===== spcfg_node.sv
// partner: remote serial node that sends on rxd and decodes txd
`timescale 1ns/1ns
`default_nettype none
module spcfg_node #(
  parameter int BIT_CLKS = 4
) (
  input wire logic core_clk,
  output logic rxd,
  input wire logic txd
);
  logic nine_mode = 1'b0;
  logic [7:0] got_q[$];
  logic got_top_q[$];
  logic [8:0] sh;
  initial rxd = 1'b1;
  // caller enters just after a clock edge; frame is start, 8 or 9 bits lsb
  // first; the ninth bit goes out only in nine-bit mode
  task automatic send(input logic [7:0] d, input logic top = 1'b0);
    logic [8:0] f;
    f = {top, d};
    rxd <= 1'b0;
    repeat (BIT_CLKS) @(posedge core_clk);
    for (int i = 0; i < (nine_mode ? 9 : 8); i++) begin
      rxd <= f[i];
      repeat (BIT_CLKS) @(posedge core_clk);
    end
    rxd <= 1'b1;
    repeat (BIT_CLKS) @(posedge core_clk);
  endtask : send
  // samples mid-bit, so small skew of the sender is tolerated
  always begin
    @(negedge txd);
    repeat (BIT_CLKS / 2) @(posedge core_clk);
    sh = 9'h000;
    for (int i = 0; i < (nine_mode ? 9 : 8); i++) begin
      repeat (BIT_CLKS) @(posedge core_clk);
      sh[i] = txd;
    end
    repeat (BIT_CLKS) @(posedge core_clk);
    got_q.push_back(sh[7:0]);
    if (nine_mode) begin
      got_top_q.push_back(sh[8]);
    end
  end
endmodule : spcfg_node
`default_nettype wire

// ===== spcfg_top_test.sv
// testbench: register, transmit, receive, idle and fifo checks
`timescale 1ns/1ns
`default_nettype none
module spcfg_top_test;
  import spcfg_pkg::*;
  typedef struct {logic [1:0] a; logic [7:0] w, r; logic [3:0] q;} spcfg_row_t;
  logic core_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, v, c;
  logic rxd, txd, irq_tx_empty, irq_tx_done, irq_rx_full, irq_idle, wake;
  int mismatches = 0, checked = 0, n;
  // irq column is {wake, tx empty, tx done, rx full}
  spcfg_row_t rows[9] = '{'{2'h0, 8'h08, 8'h08, 4'h8},
    '{2'h0, 8'h00, 8'h00, 4'h0}, '{2'h1, 8'h80, 8'h80, 4'h4},
    '{2'h1, 8'h40, 8'h40, 4'h2}, '{2'h1, 8'h20, 8'h20, 4'h0},
    '{2'h1, 8'hF0, 8'hF0, 4'h6}, '{2'h1, 8'h0F, 8'h0F, 4'h0},
    '{2'h0, 8'h0C, 8'h0C, 4'h8}, '{2'h0, 8'h00, 8'h00, 4'h0}};
  always #5 core_clk = ~core_clk;
  spcfg_top #(.FIFO_DEPTH(8), .BAUD_DIV(16'h0004)) DUT (.core_clk(core_clk),
    .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd(rxd), .txd(txd),
    .irq_tx_empty(irq_tx_empty), .irq_tx_done(irq_tx_done),
    .irq_rx_full(irq_rx_full), .irq_idle(irq_idle), .wake_addr_mark(wake));
  spcfg_node #(.BIT_CLKS(4)) u_node (.core_clk(core_clk), .rxd(rxd), .txd(txd));
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge core_clk);
  endtask : rd
  task automatic chk(input logic [7:0] g, e, input string what);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask : chk
  task automatic give_verdict;
    $display("%0d comparisons, %0d mismatches", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  // parity replaces the top bit; xor with the odd select flips the sense
  function automatic logic [7:0] ex(logic [7:0] d, logic pe, logic pt);
    return pe ? {^d[6:0] ^ pt, d[6:0]} : d;
  endfunction : ex
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    $display("Error at %0t: run did not finish in time", $time);
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, v);
      chk(v, rows[i].r, "readback");
      chk({4'h0, wake, irq_tx_empty, irq_tx_done, irq_rx_full},
          {4'h0, rows[i].q}, "irq levels");
    end
    $display("register table done");
    wr(SPCFG_ADDR_CTRL2, 8'hF0);
    nrst <= 1'b0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    rd(SPCFG_ADDR_CTRL2, v);
    chk(v, SPCFG_CTRL2_RST, "ctrl2 after reset");
    chk({7'h0, irq_tx_empty | irq_tx_done}, 8'h00, "irq after reset");
    $display("mid-run reset done");
    wr(SPCFG_ADDR_CTRL2, 8'h40);
    for (int m = 0; m < 4; m++) begin
      wr(SPCFG_ADDR_CTRL1, {6'h00, m[1:0]});
      for (int j = 0; j < 2; j++) begin
        c = (j != 0) ? 8'h26 : 8'hA6;
        wr(SPCFG_ADDR_DATA, c);
        chk({7'h0, irq_tx_done}, 8'h00, "tx done while busy");
        for (n = 0; n < 100 && u_node.got_q.size() == 0; n++) @(posedge core_clk);
        v = u_node.got_q.pop_front();
        chk(v, ex(c, m[1], m[0]), "sent character");
        for (n = 0; n < 20 && irq_tx_done !== 1'b1; n++) @(posedge core_clk);
        chk({7'h0, irq_tx_done}, 8'h01, "tx done request");
      end
    end
    $display("transmit parity done");
    wr(SPCFG_ADDR_CTRL2, 8'h20);
    for (int m = 0; m < 5; m++) begin
      if (m < 4) wr(SPCFG_ADDR_CTRL1, {6'h00, m[1:0]});
      c = ex(8'h35, m[1] | m[2], m[0] | m[2]) ^ {m[2], 7'h00};
      u_node.send(c);
      for (n = 0; n < 20 && irq_rx_full !== 1'b1; n++) @(posedge core_clk);
      chk({7'h0, irq_rx_full}, 8'h01, "rx full request");
      rd(SPCFG_ADDR_STATUS, v);
      chk({7'h0, v[SPCFG_ST_PF]}, {7'h0, m[2]}, "parity error");
      rd(SPCFG_ADDR_DATA, v);
      chk({1'b0, v[6:0]}, 8'h35, "received data");
      chk({7'h0, irq_rx_full}, 8'h00, "rx full after read");
    end
    $display("receive parity done");
    // nine-bit frames: stored ninth bit with parity off, parity with it on
    u_node.nine_mode = 1'b1;
    for (int k = 0; k < 2; k++) begin
      wr(SPCFG_ADDR_CTRL1, (k != 0) ? 8'h32 : 8'h31);
      wr(SPCFG_ADDR_DATA, 8'hA6);
      for (n = 0; n < 100 && u_node.got_q.size() == 0; n++) begin
        @(posedge core_clk);
      end
      chk(u_node.got_q.pop_front(), 8'hA6, "nine-bit character");
      c = {7'h00, u_node.got_top_q.pop_front()};
      chk(c, {7'h00, (k != 0) ? ^8'hA6 : 1'b1}, "ninth bit");
      u_node.send(8'h35, k[0]);
      for (n = 0; n < 20 && irq_rx_full !== 1'b1; n++) @(posedge core_clk);
      chk({7'h0, irq_rx_full}, 8'h01, "nine-bit rx full");
      rd(SPCFG_ADDR_STATUS, v);
      chk({7'h0, v[SPCFG_ST_PF]}, {7'h0, k[0]}, "nine-bit parity");
      rd(SPCFG_ADDR_DATA, v);
      chk(v, 8'h35, "nine-bit data");
    end
    u_node.nine_mode = 1'b0;
    $display("nine-bit mode done");
    wr(SPCFG_ADDR_CTRL2, 8'h10);
    for (int t = 0; t < 2; t++) begin
      wr(SPCFG_ADDR_CTRL1, t ? 8'h04 : 8'h00);
      rd(SPCFG_ADDR_STATUS, v);
      rd(SPCFG_ADDR_DATA, v);
      u_node.send(8'hFF);
      for (n = 0; n < 100 && irq_idle !== 1'b1; n++) @(posedge core_clk);
      // ten bit times of 4 clocks; the stop bit counts only for type 0
      if (t) chk({7'h0, n >= 32 && n <= 48}, 8'h01, "idle from stop");
      else chk({7'h0, n < 20}, 8'h01, "idle from start");
    end
    $display("idle line done");
    wr(SPCFG_ADDR_CTRL1, 8'h00);
    wr(SPCFG_ADDR_CTRL2, 8'h80);
    for (int i = 0; i < 10; i++) wr(SPCFG_ADDR_DATA, 8'h50 + i[7:0]);
    rd(SPCFG_ADDR_STATUS, v);
    chk({7'h0, v[SPCFG_ST_TX_BUFFER_EMPTY_FLAG]}, 8'h00, "buffer full flag");
    chk({7'h0, irq_tx_empty}, 8'h00, "tx empty while full");
    for (n = 0; n < 600 && u_node.got_q.size() < 8; n++) @(posedge core_clk);
    repeat (100) @(posedge core_clk);
    chk({7'h0, irq_tx_empty}, 8'h01, "tx empty after drain");
    n = u_node.got_q.size();
    // one character in flight plus eight queued; the tenth write is dropped
    chk({7'h0, n == 9}, 8'h01, "characters kept");
    for (int i = 0; i < 9; i++) chk(u_node.got_q[i], 8'h50 + i[7:0], "order");
    $display("fifo fill done");
    give_verdict();
  end
endmodule : spcfg_top_test
`default_nettype wire
